// file: pcs_delim_coder.v
// gigabit coding sublayer: delimiter selection, low-power request, receive and descramble
`timescale 1ns/1ps
`include "pcs_delim_regs.vh"

module pcs_delim_coder #(
  parameter ENERGY_SAVING_OPTION = 1,
  parameter TAP_MASTER = 13,
  parameter TAP_SLAVE = 20,
  parameter [`ROW_COUNT*`SYMB_W-1:0] ROW_SYMBOLS = {
    12'h249, 12'h492, 12'h924, 12'h111, 12'h222, 12'h444, 12'h888,
    12'h0F0, 12'h00F, 12'h333, 12'h000, 12'h666, 12'h555, 12'h000}
) (
  input wire I_SYS_CLK,
  input wire I_SYS_RST,
  input wire I_TX_EN,
  input wire I_TX_ER,
  input wire [7:0] I_TXD,
  input wire I_MASTER,
  input wire I_RX_SYMB_VALID,
  input wire [3:0] I_RX_ROW,
  input wire [7:0] I_RX_SCRAMBLED,
  input wire I_RX_READY,
  output reg [3:0] O_TX_ROW,
  output reg [11:0] O_TX_SYMB,
  output reg [7:0] O_TX_SCRAMBLED,
  output reg O_LOC_LPI_REQ,
  output reg O_REM_LPI_REQ,
  output wire O_RX_SYMB_READY,
  output wire O_RX_VALID,
  output wire O_RX_DV,
  output wire O_RX_ER,
  output wire [7:0] O_RXD
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function [`SYMB_W-1:0] row_lookup;
    input [3:0] row;
    input [7:0] sd;
    begin
      if (row == `ROW_DATA) begin
        row_lookup = {1'b0, sd[7:6], 1'b0, sd[5:4], 1'b0, sd[3:2], 1'b0, sd[1:0]};
      end else if (row < `ROW_COUNT) begin
        row_lookup = ROW_SYMBOLS[row*`SYMB_W +: `SYMB_W];
      end else begin
        row_lookup = {`SYMB_W{1'b0}};
      end
    end
  endfunction

  function [`SCR_W-1:0] lfsr_step;
    input [`SCR_W-1:0] s;
    input master;
    reg fb;
    begin
      fb = master ? (s[`SCR_W-1] ^ s[TAP_MASTER-1]) : (s[`SCR_W-1] ^ s[TAP_SLAVE-1]);
      lfsr_step = {s[`SCR_W-2:0], fb};
    end
  endfunction

  // ----------------------------------------------------------------
  // transmit flag history
  // ----------------------------------------------------------------
  reg [`HIST_DEPTH:1] en_hist_r;
  reg [`HIST_DEPTH:1] er_hist_r;

  always @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      en_hist_r <= {`HIST_DEPTH{1'b0}};
      er_hist_r <= {`HIST_DEPTH{1'b0}};
    end else begin
      en_hist_r <= {en_hist_r[`HIST_DEPTH-1:1], I_TX_EN};
      er_hist_r <= {er_hist_r[`HIST_DEPTH-1:1], I_TX_ER};
    end
  end

  // ----------------------------------------------------------------
  // transmit scrambler
  // ----------------------------------------------------------------
  reg [`SCR_W-1:0] tx_scr_r;
  wire [`SCR_W-1:0] tx_scr_step = lfsr_step(tx_scr_r, I_MASTER);
  wire [7:0] scrambled_data_bits = I_TXD ^ tx_scr_r[7:0];

  always @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      tx_scr_r <= `SCR_SEED;
    end else if (tx_scr_step == {`SCR_W{1'b0}}) begin
      // a zero state would lock the generator forever
      tx_scr_r <= `SCR_SEED;
    end else begin
      tx_scr_r <= tx_scr_step;
    end
  end

  // ----------------------------------------------------------------
  // transmit row selection
  // ----------------------------------------------------------------
  wire en0 = I_TX_EN;
  wire en1 = en_hist_r[1];
  wire en2 = en_hist_r[2];
  wire en3 = en_hist_r[3];
  wire en4 = en_hist_r[4];
  wire er0 = I_TX_ER;
  wire er1 = er_hist_r[1];
  wire er2 = er_hist_r[2];
  wire er3 = er_hist_r[3];
  wire ext_req = er0 && !en0;
  wire ext_err = ext_req && (I_TXD != `TXD_EXTEND_OK);
  wire lpi_assert = !en0 && er0 && (I_TXD == `TXD_LPI_ASSERT);
  wire in_end_delim = (!en2 && en3) || (!en3 && en4);
  reg [3:0] row_nxt;

  always @* begin
    row_nxt = `ROW_IDLE;
    if (en0 && !en1) begin
      row_nxt = `ROW_START_DELIM_FIRST;
    end else if (en1 && !en2) begin
      row_nxt = `ROW_START_DELIM_SECOND;
    end else if (en0) begin
      row_nxt = er0 ? `ROW_XMT_ERR : `ROW_DATA;
    end else if (in_end_delim && ext_err) begin
      row_nxt = `ROW_END_DELIM_EXTENSION_FAULT;
    end else if (!en2 && en3) begin
      row_nxt = `ROW_END_DELIM_FIRST;
    end else if (!en3 && en4) begin
      if (!er0 && !er1) begin
        row_nxt = `ROW_END_DELIM_SECOND_VAR0;
      end else if (!er0 && er1 && er2 && er3) begin
        row_nxt = `ROW_END_DELIM_SECOND_VAR1;
      end else if (er0 && er1 && er2 && er3 && I_TXD == `TXD_EXTEND_OK) begin
        row_nxt = `ROW_END_DELIM_SECOND_VAR2;
      end else begin
        // partial error run falls outside every variant; flag it as a fault
        row_nxt = `ROW_END_DELIM_EXTENSION_FAULT;
      end
    end else if (en1 || en2) begin
      // convolutional reset periods right after the frame
      if (ext_err || (!ext_req && er1 && en1)) begin
        row_nxt = `ROW_CS_EXTEND_ERR;
      end else if (ext_req) begin
        row_nxt = `ROW_CS_EXTEND;
      end else begin
        row_nxt = `ROW_CS_RESET;
      end
    end else if (lpi_assert && ENERGY_SAVING_OPTION != 0) begin
      row_nxt = `ROW_LPI;
    end
  end

  always @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_TX_ROW <= `ROW_IDLE;
      O_TX_SYMB <= {`SYMB_W{1'b0}};
      O_TX_SCRAMBLED <= 8'h00;
    end else begin
      O_TX_ROW <= row_nxt;
      O_TX_SYMB <= row_lookup(row_nxt, scrambled_data_bits);
      O_TX_SCRAMBLED <= scrambled_data_bits;
    end
  end

  // ----------------------------------------------------------------
  // local low-power request machine
  // ----------------------------------------------------------------
  localparam LPI_INACTIVE = 2'b01;
  localparam LPI_ACTIVE = 2'b10;
  reg [1:0] lpi_state_r;
  reg [1:0] lpi_state_nxt;

  always @* begin
    case (lpi_state_r)
      LPI_INACTIVE: lpi_state_nxt = lpi_assert ? LPI_ACTIVE : LPI_INACTIVE;
      LPI_ACTIVE: lpi_state_nxt = lpi_assert ? LPI_ACTIVE : LPI_INACTIVE;
      default: lpi_state_nxt = LPI_INACTIVE;
    endcase
  end

  always @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      lpi_state_r <= LPI_INACTIVE;
      O_LOC_LPI_REQ <= 1'b0;
    end else if (ENERGY_SAVING_OPTION != 0) begin
      lpi_state_r <= lpi_state_nxt;
      O_LOC_LPI_REQ <= (lpi_state_nxt == LPI_ACTIVE);
    end else begin
      lpi_state_r <= LPI_INACTIVE;
      O_LOC_LPI_REQ <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // receive state machine and descrambler
  // ----------------------------------------------------------------
  localparam RX_IDLE = 4'b0001;
  localparam RX_START = 4'b0010;
  localparam RX_DATA = 4'b0100;
  localparam RX_END = 4'b1000;
  reg [3:0] rx_state_r;
  reg [3:0] rx_state_nxt;
  reg [`SCR_W-1:0] rx_scr_r;
  reg push_nxt;
  reg dv_nxt;
  reg er_nxt;
  wire buf_in_ready;
  wire rx_take = I_RX_SYMB_VALID && buf_in_ready;
  wire [7:0] rx_plain = I_RX_SCRAMBLED ^ rx_scr_r[7:0];

  always @* begin
    rx_state_nxt = rx_state_r;
    push_nxt = 1'b0;
    dv_nxt = 1'b0;
    er_nxt = 1'b0;
    case (rx_state_r)
      RX_IDLE: begin
        if (I_RX_ROW == `ROW_START_DELIM_FIRST) begin
          rx_state_nxt = RX_START;
        end
      end
      RX_START: begin
        if (I_RX_ROW == `ROW_START_DELIM_SECOND) begin
          rx_state_nxt = RX_DATA;
        end else begin
          // broken start: report a false carrier and resync
          push_nxt = 1'b1;
          er_nxt = 1'b1;
          rx_state_nxt = RX_IDLE;
        end
      end
      RX_DATA: begin
        push_nxt = 1'b1;
        dv_nxt = 1'b1;
        if (I_RX_ROW == `ROW_DATA) begin
          er_nxt = 1'b0;
        end else if (I_RX_ROW == `ROW_XMT_ERR) begin
          er_nxt = 1'b1;
        end else if (I_RX_ROW == `ROW_CS_RESET || I_RX_ROW == `ROW_CS_EXTEND ||
                     I_RX_ROW == `ROW_CS_EXTEND_ERR) begin
          push_nxt = 1'b0;
          dv_nxt = 1'b0;
          rx_state_nxt = RX_END;
        end else begin
          er_nxt = 1'b1;
          rx_state_nxt = RX_END;
        end
      end
      RX_END: begin
        if (I_RX_ROW != `ROW_CS_RESET && I_RX_ROW != `ROW_CS_EXTEND &&
            I_RX_ROW != `ROW_CS_EXTEND_ERR && I_RX_ROW != `ROW_END_DELIM_FIRST) begin
          rx_state_nxt = RX_IDLE;
        end
      end
      default: rx_state_nxt = RX_IDLE;
    endcase
  end

  always @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      rx_state_r <= RX_IDLE;
      rx_scr_r <= `SCR_SEED;
      O_REM_LPI_REQ <= 1'b0;
    end else begin
      if (rx_take) begin
        rx_state_r <= rx_state_nxt;
        // role picks the generator; zero state reseeded as on transmit
        if (lfsr_step(rx_scr_r, ~I_MASTER) == {`SCR_W{1'b0}}) begin
          rx_scr_r <= `SCR_SEED;
        end else begin
          rx_scr_r <= lfsr_step(rx_scr_r, ~I_MASTER);
        end
        if (ENERGY_SAVING_OPTION != 0) begin
          O_REM_LPI_REQ <= (I_RX_ROW == `ROW_LPI);
        end
      end
      if (ENERGY_SAVING_OPTION == 0) begin
        O_REM_LPI_REQ <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // receive buffer toward the reconciliation side
  // ----------------------------------------------------------------
  // a stall lowers the registered ready; symbols offered meanwhile are not taken
  pcs_skid_buf #(
    .WIDTH(10),
    .DEPTH(2)
  ) u_rx_buf (
    .i_clk(I_SYS_CLK),
    .i_rst(I_SYS_RST),
    .i_in_valid(rx_take && push_nxt),
    .i_in_data({dv_nxt, er_nxt, rx_plain}),
    .o_in_ready(buf_in_ready),
    .o_out_valid(O_RX_VALID),
    .o_out_data({O_RX_DV, O_RX_ER, O_RXD}),
    .i_out_ready(I_RX_READY)
  );

  assign O_RX_SYMB_READY = buf_in_ready;

endmodule // pcs_delim_coder

// file: pcs_delim_regs.vh
// constants for the gigabit delimiter coder: row codes, field values, seeds
`ifndef PCS_DELIM_REGS_VH
`define PCS_DELIM_REGS_VH

// ----------------------------------------------------------------
// symbol row codes shared by transmit selection and receive decode
// ----------------------------------------------------------------
`define ROW_W 4
`define ROW_IDLE 4'h0
`define ROW_START_DELIM_FIRST 4'h1
`define ROW_START_DELIM_SECOND 4'h2
`define ROW_DATA 4'h3
`define ROW_XMT_ERR 4'h4
`define ROW_CS_RESET 4'h5
`define ROW_CS_EXTEND 4'h6
`define ROW_CS_EXTEND_ERR 4'h7
`define ROW_END_DELIM_FIRST 4'h8
`define ROW_END_DELIM_EXTENSION_FAULT 4'h9
`define ROW_END_DELIM_SECOND_VAR0 4'hA
`define ROW_END_DELIM_SECOND_VAR1 4'hB
`define ROW_END_DELIM_SECOND_VAR2 4'hC
`define ROW_LPI 4'hD
`define ROW_COUNT 14

// ----------------------------------------------------------------
// field values and widths
// ----------------------------------------------------------------
`define TXD_EXTEND_OK 8'h0F
`define TXD_LPI_ASSERT 8'h01
`define SYMB_W 12
`define HIST_DEPTH 4
`define SCR_W 33
`define SCR_SEED 33'h000000001

`endif

// file: pcs_skid_buf.v
// two-entry valid/ready buffer holding receive words
`timescale 1ns/1ps
module pcs_skid_buf #(
  parameter WIDTH = 10,
  parameter DEPTH = 2
) (
  input wire i_clk,
  input wire i_rst,
  input wire i_in_valid,
  input wire [WIDTH-1:0] i_in_data,
  output reg o_in_ready,
  output reg o_out_valid,
  output reg [WIDTH-1:0] o_out_data,
  input wire i_out_ready
);
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [1:0] cnt_r;
  reg [1:0] cnt_nxt;
  reg rd_ptr_r;
  reg wr_ptr_r;
  wire push = i_in_valid && o_in_ready;
  wire pop = o_out_valid && i_out_ready;
  integer k;

  always @* begin
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = cnt_r + 2'd1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 2'd1;
    end
  end

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_r <= 2'd0;
      rd_ptr_r <= 1'b0;
      wr_ptr_r <= 1'b0;
      o_in_ready <= 1'b0;
      o_out_valid <= 1'b0;
      o_out_data <= {WIDTH{1'b0}};
      for (k = 0; k < DEPTH; k = k + 1) begin
        mem_r[k] <= {WIDTH{1'b0}};
      end
    end else begin
      cnt_r <= cnt_nxt;
      // ready is registered so the source sees honest back-pressure
      o_in_ready <= (cnt_nxt < DEPTH);
      if (push) begin
        mem_r[wr_ptr_r] <= i_in_data;
        wr_ptr_r <= ~wr_ptr_r;
      end
      if (pop) begin
        rd_ptr_r <= ~rd_ptr_r;
      end
      o_out_valid <= (cnt_nxt != 2'd0);
      if (cnt_nxt != 2'd0) begin
        if (cnt_r == 2'd0 || (pop && cnt_r == 2'd1)) begin
          o_out_data <= i_in_data;
        end else if (pop) begin
          o_out_data <= mem_r[~rd_ptr_r];
        end else begin
          o_out_data <= mem_r[rd_ptr_r];
        end
      end
    end
  end
endmodule // pcs_skid_buf

// file: pcs_delim_coder_properties.sv
// checker for delimiter rows and receive word hold
`timescale 1ns/1ps
`include "pcs_delim_regs.vh"
module pcs_delim_coder_properties (
  input wire I_SYS_CLK,
  input wire I_SYS_RST,
  input wire I_TX_EN,
  input wire I_TX_ER,
  input wire [7:0] I_TXD,
  input wire I_RX_READY,
  input wire [3:0] O_TX_ROW,
  input wire O_RX_VALID,
  input wire O_RX_DV,
  input wire O_RX_ER,
  input wire [7:0] O_RXD
);
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (I_SYS_RST);
  sequence fall_s;
    I_TX_EN ##1 !I_TX_EN;
  endsequence
  // a new frame inside the end window is left out on purpose
  sequence quiet_s;
    fall_s ##1 !I_TX_EN;
  endsequence
  start_first_a: assert property (!I_TX_EN ##1 I_TX_EN |=> O_TX_ROW == `ROW_START_DELIM_FIRST)
    else $error("first start row wrong");
  start_second_a: assert property (!I_TX_EN ##1 I_TX_EN [*2] |=> O_TX_ROW == `ROW_START_DELIM_SECOND)
    else $error("second start row wrong");
  data_error_a: assert property (I_TX_EN [*2] ##1 (I_TX_EN && I_TX_ER) |=> O_TX_ROW == `ROW_XMT_ERR)
    else $error("error row wrong");
  end_first_a: assert property (quiet_s ##1 (!I_TX_EN && !I_TX_ER) |=> O_TX_ROW == `ROW_END_DELIM_FIRST)
    else $error("first end row wrong");
  ext_fault_row_a: assert property (quiet_s ##1 (!I_TX_EN && I_TX_ER && I_TXD != `TXD_EXTEND_OK)
    |=> O_TX_ROW == `ROW_END_DELIM_EXTENSION_FAULT) else $error("extension fault row wrong");
  end_var0_a: assert property (quiet_s ##1 (!I_TX_EN && !I_TX_ER) [*2]
    |=> O_TX_ROW == `ROW_END_DELIM_SECOND_VAR0) else $error("end variant zero wrong");
  end_var1_a: assert property (fall_s ##0 I_TX_ER ##1 (!I_TX_EN && I_TX_ER) [*2]
    ##1 (!I_TX_EN && !I_TX_ER) |=> O_TX_ROW == `ROW_END_DELIM_SECOND_VAR1) else $error("end variant one wrong");
  end_var2_a: assert property (fall_s ##0 I_TX_ER ##1 (!I_TX_EN && I_TX_ER) [*2]
    ##1 (!I_TX_EN && I_TX_ER && I_TXD == `TXD_EXTEND_OK) |=> O_TX_ROW == `ROW_END_DELIM_SECOND_VAR2)
    else $error("end variant two wrong");
  rx_word_hold_a: assert property (O_RX_VALID && !I_RX_READY
    |=> O_RX_VALID && $stable({O_RX_DV, O_RX_ER, O_RXD})) else $error("receive word not held");
endmodule // pcs_delim_coder_properties
bind pcs_delim_coder pcs_delim_coder_properties chk (.I_SYS_CLK, .I_SYS_RST, .I_TX_EN, .I_TX_ER, .I_TXD,
  .I_RX_READY, .O_TX_ROW, .O_RX_VALID, .O_RX_DV, .O_RX_ER, .O_RXD);

// file: rs_rx_model.sv
// receive side of the reconciliation model: stalls on command, records words
`timescale 1ns/1ps
module rs_rx_model (
  input wire i_clk,
  input wire i_clr,
  input wire i_stall,
  input wire i_valid,
  input wire [9:0] i_word,
  output wire o_ready
);
  reg [9:0] words [0:15];
  reg [3:0] count;
  // a slow answer is a plain stall; the word must wait inside the block
  assign o_ready = !i_stall;
  always @(posedge i_clk) begin
    if (i_clr) begin
      count <= 4'h0;
    end else if (i_valid && o_ready) begin
      words[count] <= i_word;
      count <= count + 4'h1;
    end
  end
endmodule // rs_rx_model

// file: gigabit_pcs_delimiter_coding_test.sv
// bench: two coders cross-linked over symbol rows, receive model on uut
`timescale 1ns/1ps
`include "pcs_delim_regs.vh"
module gigabit_pcs_delimiter_coding_test;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg en = 1'b0;
  reg er = 1'b0;
  reg role = 1'b1;
  reg stall = 1'b0;
  reg [7:0] txd = 8'h00;
  wire [3:0] row, prow;
  wire [7:0] sc, psc, rxd;
  wire rdy, srdy, vld, dv, rer, lpi, rlpi;
  wire [11:0] symb;
  wire lpi0, rlpi0;
  integer mismatches = 0;
  integer samples_checked = 0;
  always #5 clk = ~clk;
  pcs_delim_coder uut (.I_SYS_CLK(clk), .I_SYS_RST(rst), .I_TX_EN(en), .I_TX_ER(er), .I_TXD(txd),
    .I_MASTER(role), .I_RX_SYMB_VALID(1'b1), .I_RX_ROW(prow), .I_RX_SCRAMBLED(psc), .I_RX_READY(rdy),
    .O_TX_ROW(row), .O_TX_SYMB(symb), .O_TX_SCRAMBLED(sc), .O_LOC_LPI_REQ(lpi), .O_REM_LPI_REQ(rlpi),
    .O_RX_SYMB_READY(srdy), .O_RX_VALID(vld), .O_RX_DV(dv), .O_RX_ER(rer), .O_RXD(rxd));
  // opposite role, so its transmit generator is the one uut must descramble with
  pcs_delim_coder peer (.I_SYS_CLK(clk), .I_SYS_RST(rst), .I_TX_EN(en), .I_TX_ER(er), .I_TXD(txd),
    .I_MASTER(!role), .I_RX_SYMB_VALID(1'b1), .I_RX_ROW(row), .I_RX_SCRAMBLED(sc), .I_RX_READY(1'b1),
    .O_TX_ROW(prow), .O_TX_SYMB(), .O_TX_SCRAMBLED(psc), .O_LOC_LPI_REQ(), .O_REM_LPI_REQ(),
    .O_RX_SYMB_READY(), .O_RX_VALID(), .O_RX_DV(), .O_RX_ER(), .O_RXD());
  // option absent: both low-power requests must read false
  pcs_delim_coder #(.ENERGY_SAVING_OPTION(0)) nolpi (.I_SYS_CLK(clk), .I_SYS_RST(rst), .I_TX_EN(en), .I_TX_ER(er),
    .I_TXD(txd), .I_MASTER(role), .I_RX_SYMB_VALID(1'b1), .I_RX_ROW(prow), .I_RX_SCRAMBLED(psc), .I_RX_READY(1'b1),
    .O_TX_ROW(), .O_TX_SYMB(), .O_TX_SCRAMBLED(), .O_LOC_LPI_REQ(lpi0), .O_REM_LPI_REQ(rlpi0),
    .O_RX_SYMB_READY(), .O_RX_VALID(), .O_RX_DV(), .O_RX_ER(), .O_RXD());
  rs_rx_model rs (.i_clk(clk), .i_clr(rst), .i_stall(stall), .i_valid(vld), .i_word({dv, rer, rxd}),
    .o_ready(rdy));
  task chk(input [31:0] got, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task drive(input e, input r, input [7:0] d);
    begin
      en = e;
      er = r;
      txd = d;
      @(posedge clk);
      #1;
    end
  endtask
  task restart(input m);
    begin
      role = m;
      rst = 1'b1;
      stall = 1'b0;
      repeat (16) drive(0, 0, 8'h00);
      rst = 1'b0;
      repeat (2) drive(0, 0, 8'h00);
    end
  endtask
  task frame_test(input m);
    integer i;
    begin
      restart(m);
      for (i = 0; i < 6; i = i + 1) begin
        drive(1, 0, 8'hA0 + i[7:0]);
        chk(row, i == 0 ? 4'h1 : i == 1 ? 4'h2 : 4'h3);
        if (i > 1) chk(symb, {1'b0, sc[7:6], 1'b0, sc[5:4], 1'b0, sc[3:2], 1'b0, sc[1:0]});
      end
      repeat (3) drive(0, 0, 8'h00);
      chk(row, `ROW_END_DELIM_FIRST);
      drive(0, 0, 8'h00);
      chk(row, `ROW_END_DELIM_SECOND_VAR0);
      repeat (4) drive(0, 0, 8'h00);
      chk(rs.count, 4);
      for (i = 0; i < 4; i = i + 1) chk(rs.words[i], {2'b10, 8'hA2 + i[7:0]});
    end
  endtask
  task err_test;
    begin
      restart(1'b1);
      repeat (3) drive(1, 0, 8'h11);
      drive(1, 1, 8'h22);
      chk(row, `ROW_XMT_ERR);
      repeat (8) drive(0, 0, 8'h00);
      chk(rs.words[1][9:8], 2'b11);
    end
  endtask
  task end_test(input [3:0] msk, input [7:0] d3, input [3:0] r3, input [3:0] r4);
    integer k;
    begin
      restart(1'b1);
      repeat (3) drive(1, 0, 8'h33);
      for (k = 0; k < 4; k = k + 1) begin
        drive(0, msk[k], k == 2 ? d3 : `TXD_EXTEND_OK);
        if (k == 2) chk(row, r3);
        if (k == 3) chk(row, r4);
      end
      repeat (4) drive(0, 0, 8'h00);
    end
  endtask
  task lpi_test;
    begin
      restart(1'b1);
      repeat (8) drive(0, 1, `TXD_LPI_ASSERT);
      chk(lpi, 1'b1);
      chk(rlpi, 1'b1);
      chk(row, `ROW_LPI);
      chk(lpi0, 1'b0);
      chk(rlpi0, 1'b0);
      repeat (8) drive(0, 0, 8'h00);
      chk(lpi, 1'b0);
    end
  endtask
  task buf_test;
    integer i;
    begin
      restart(1'b0);
      stall = 1'b1;
      for (i = 0; i < 8; i = i + 1) drive(1, 0, 8'hC0 + i[7:0]);
      chk(srdy, 1'b0);
      chk(rs.count, 0);
      repeat (4) drive(0, 0, 8'h00);
      stall = 1'b0;
      repeat (4) drive(0, 0, 8'h00);
      // rows dropped by the stall cut the frame: one error word closes it
      chk(rs.count, 3);
      chk(rs.words[0], {2'b10, 8'hC2});
      chk(rs.words[1], {2'b10, 8'hC3});
      chk(rs.words[2][9:8], 2'b11);
    end
  endtask
  task tally_and_finish;
    begin
      $display("compares %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  initial begin
    frame_test(1'b1);
    frame_test(1'b0);
    err_test;
    end_test(4'b0111, `TXD_EXTEND_OK, 4'h8, 4'hB);
    end_test(4'b1111, `TXD_EXTEND_OK, 4'h8, 4'hC);
    end_test(4'b0100, 8'h1F, 4'h9, 4'h9);
    lpi_test;
    buf_test;
    tally_and_finish;
  end
  // all scenarios need well under 1000 cycles; a hang stops here
  initial begin
    #20000;
    mismatches = mismatches + 1;
    tally_and_finish;
  end
endmodule // gigabit_pcs_delimiter_coding_test
